// *** hmac_pkg.sv ***
package hmac_pkg;
   // instruction field layout, bit 0 is the msb (big-endian numbering)
   localparam int INSN_W = 32;
   localparam logic [5:0] PRIMARY_OP = 6'h04;
   localparam int PRI_HI = 31;    // bits 0-5
   localparam int PRI_LO = 26;
   localparam int RT_HI = 25;     // bits 6-10
   localparam int RT_LO = 21;
   localparam int RA_HI = 20;     // bits 11-15
   localparam int RA_LO = 16;
   localparam int RB_HI = 15;     // bits 16-20
   localparam int RB_LO = 11;
   localparam int OE_BIT = 10;    // bit 21
   localparam int XO_HI = 9;      // bits 22-30
   localparam int XO_LO = 1;
   localparam int RC_BIT = 0;     // bit 31
   // halfword choice sits in the top two extended opcode bits (bits 22-23)
   localparam int XO_SEL_HI = 8;
   localparam int XO_SEL_LO = 7;
   localparam logic [1:0] XO_SEL_LL = 2'h3;   // both low halfwords
   localparam logic [1:0] XO_SEL_LH = 2'h1;   // cross: low first, high second
   // extended opcodes
   localparam logic [8:0] XO_CHW_U = 9'h08C;   // 140
   localparam logic [8:0] XO_CHW_S = 9'h0AC;   // 172
   localparam logic [8:0] XO_CHW_SS = 9'h0EC;  // 236
   localparam logic [8:0] XO_CHW_SU = 9'h0CC;  // 204
   localparam logic [8:0] XO_HHW_S = 9'h02C;   // 44
   localparam logic [8:0] XO_HHW_SS = 9'h06C;  // 108
   localparam logic [8:0] XO_HHW_SU = 9'h04C;  // 76
   localparam logic [8:0] XO_HHW_U = 9'h00C;   // 12
   localparam logic [8:0] XO_LHW_S = 9'h1AC;   // 428
   localparam logic [8:0] XO_LHW_SS = 9'h1EC;  // 492
   localparam logic [8:0] XO_LHW_SU = 9'h1CC;  // 460
   localparam logic [8:0] XO_LHW_U = 9'h18C;   // 396
   // condition field bits: lt gt eq so
   localparam int CF_LT = 3;
   localparam int CF_GT = 2;
   localparam int CF_EQ = 1;
   localparam int CF_SO = 0;
   // reset values
   localparam logic [31:0] WORD_RST = 32'h00000000;
   localparam logic [3:0] CF_RST = 4'h0;
   localparam logic [4:0] REG_RST = 5'h00;
   // operand halfword selection
   typedef enum {HMAC_SEL_HH, HMAC_SEL_LL, HMAC_SEL_LH} hmac_sel_e;
   // result treatment
   typedef enum {HMAC_MODE_WRAP, HMAC_MODE_SSAT, HMAC_MODE_USAT} hmac_mode_e;
endpackage

// *** hmac_mult.sv ***
`timescale 1ns/1ps
// registered 16x16 multiplier, signed or unsigned
module hmac_mult (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [15:0] op_a,
   input wire logic [15:0] op_b,
   input wire logic is_signed,
   output logic [31:0] prod
);
   // operands widened by sign or zero
   wire logic signed [16:0] ext_a = {is_signed & op_a[15], op_a};
   wire logic signed [16:0] ext_b = {is_signed & op_b[15], op_b};
   wire logic signed [33:0] full = ext_a * ext_b;

   ////////////////////////////////////////////////////////////////
   // product register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prod <= hmac_pkg::WORD_RST;
      end else begin
         prod <= full[31:0];
      end
   end
endmodule

// *** hmac_datapath.sv ***
`timescale 1ns/1ps
// How it works
// [RULE_01] high variants multiply both upper halfwords
// [RULE_02] low variants multiply both lower halfwords
// [RULE_03] cross variant: low first, high second
// [RULE_04] signed wrap keeps low 32 sum bits
// [RULE_05] unsigned wrap drops the carry out
// [RULE_06] signed saturate clamps on same-sign overflow
// [RULE_07] unsigned saturate forces all ones on carry
// [RULE_08] record bit updates condition field zero
// [RULE_09] overflow enable updates summary and current flags
// [RULE_10] low unsigned wrap multiplies low halfwords
// [RULE_11] decode primary 4, register fields, opcode
// [RULE_12] condition shows sign, zero and summary flag
module hmac_datapath (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire logic [31:0] insn,
   input wire logic [31:0] first_source_reg,
   input wire logic [31:0] second_source_reg,
   input wire logic [31:0] accumulator_dest_reg,
   input wire logic summary_flag_in,
   output logic result_valid,
   output logic [31:0] result,
   output logic [4:0] dest_index,
   output logic illegal_op,
   output logic record_condition_bit,
   output logic [3:0] condition_field_zero,
   output logic overflow_update,
   output logic result_too_wide_flag,
   output logic summary_overflow_flag
);
   ////////////////////////////////////////////////////////////////
   // decode
   wire logic [5:0] primary = insn[hmac_pkg::PRI_HI:hmac_pkg::PRI_LO];
   wire logic [8:0] xop = insn[hmac_pkg::XO_HI:hmac_pkg::XO_LO];
   wire logic [4:0] rt_field = insn[hmac_pkg::RT_HI:hmac_pkg::RT_LO];
   wire logic oe_field = insn[hmac_pkg::OE_BIT];
   wire logic rc_field = insn[hmac_pkg::RC_BIT];

   // opcode membership tests
   function automatic logic is_sat_s(input logic [8:0] x);
      return x == hmac_pkg::XO_CHW_SS || x == hmac_pkg::XO_HHW_SS
         || x == hmac_pkg::XO_LHW_SS;
   endfunction
   function automatic logic is_sat_u(input logic [8:0] x);
      return x == hmac_pkg::XO_CHW_SU || x == hmac_pkg::XO_HHW_SU
         || x == hmac_pkg::XO_LHW_SU;
   endfunction
   function automatic logic is_wrap_s(input logic [8:0] x);
      return x == hmac_pkg::XO_CHW_S || x == hmac_pkg::XO_HHW_S
         || x == hmac_pkg::XO_LHW_S;
   endfunction
   function automatic logic is_wrap_u(input logic [8:0] x);
      return x == hmac_pkg::XO_CHW_U || x == hmac_pkg::XO_HHW_U
         || x == hmac_pkg::XO_LHW_U;
   endfunction

   // known opcode under primary 4
   wire logic known = is_sat_s(xop) | is_sat_u(xop) | is_wrap_s(xop) | is_wrap_u(xop);
   wire logic prim_ok = primary == hmac_pkg::PRIMARY_OP; // RULE_11
   wire logic accept = issue_valid & prim_ok & known; // RULE_11
   wire logic reject = issue_valid & ~accept;
   wire logic op_signed = is_sat_s(xop) | is_wrap_s(xop);

   // halfword selection from opcode bits 22-23
   hmac_pkg::hmac_sel_e sel;
   wire logic [1:0] sel_code = xop[hmac_pkg::XO_SEL_HI:hmac_pkg::XO_SEL_LO];
   assign sel = (sel_code == hmac_pkg::XO_SEL_LL) ? hmac_pkg::HMAC_SEL_LL
      : (sel_code == hmac_pkg::XO_SEL_LH) ? hmac_pkg::HMAC_SEL_LH : hmac_pkg::HMAC_SEL_HH;

   // result treatment
   hmac_pkg::hmac_mode_e mode;
   assign mode = is_sat_s(xop) ? hmac_pkg::HMAC_MODE_SSAT
      : is_sat_u(xop) ? hmac_pkg::HMAC_MODE_USAT : hmac_pkg::HMAC_MODE_WRAP;

   ////////////////////////////////////////////////////////////////
   // operand selection
   wire logic [15:0] a_hi = first_source_reg[31:16];
   wire logic [15:0] a_lo = first_source_reg[15:0];
   wire logic [15:0] b_hi = second_source_reg[31:16];
   wire logic [15:0] b_lo = second_source_reg[15:0];
   logic [15:0] mul_a;
   logic [15:0] mul_b;
   always_comb begin
      unique case (sel)
         hmac_pkg::HMAC_SEL_HH: begin
            mul_a = a_hi; // RULE_01
            mul_b = b_hi; // RULE_01
         end
         hmac_pkg::HMAC_SEL_LL: begin
            mul_a = a_lo; // RULE_02 RULE_10
            mul_b = b_lo; // RULE_02 RULE_10
         end
         hmac_pkg::HMAC_SEL_LH: begin
            mul_a = a_lo; // RULE_03
            mul_b = b_hi; // RULE_03
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // stage 1: multiply while capturing the rest of the operation
   logic [31:0] prod;
   hmac_mult u_mult (
      .mclk(mclk),
      .rst_n(rst_n),
      .op_a(mul_a),
      .op_b(mul_b),
      .is_signed(op_signed),
      .prod(prod)
   );

   logic s1_valid;
   logic s1_bad;
   logic [31:0] s1_acc;
   logic [4:0] s1_rt;
   logic s1_oe;
   logic s1_rc;
   logic s1_signed;
   hmac_pkg::hmac_mode_e s1_mode;

   // stage 1 control and data capture
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_valid <= 1'b0;
         s1_bad <= 1'b0;
         s1_acc <= hmac_pkg::WORD_RST;
         s1_rt <= hmac_pkg::REG_RST;
         s1_oe <= 1'b0;
         s1_rc <= 1'b0;
         s1_signed <= 1'b0;
         s1_mode <= hmac_pkg::HMAC_MODE_WRAP;
      end else begin
         s1_valid <= accept;
         s1_bad <= reject;
         s1_acc <= accumulator_dest_reg;
         s1_rt <= rt_field;
         s1_oe <= oe_field;
         s1_rc <= rc_field;
         s1_signed <= op_signed;
         s1_mode <= mode;
      end
   end

   ////////////////////////////////////////////////////////////////
   // stage 2: accumulate and saturate
   wire logic [32:0] sum = {1'b0, prod} + {1'b0, s1_acc}; // RULE_04 RULE_05
   wire logic [31:0] wrap_res = sum[31:0]; // RULE_04 RULE_05 RULE_10
   wire logic s_ovf = (prod[31] == s1_acc[31]) && (s1_acc[31] != sum[31]); // RULE_06
   wire logic u_ovf = sum[32]; // RULE_07
   wire logic [31:0] ssat_res = {s1_acc[31], {31{~s1_acc[31]}}}; // RULE_06
   wire logic [31:0] usat_res = 32'hFFFFFFFF; // RULE_07

   logic [31:0] next_result;
   logic next_ovf;
   always_comb begin
      unique case (s1_mode)
         hmac_pkg::HMAC_MODE_SSAT: begin
            next_result = s_ovf ? ssat_res : wrap_res; // RULE_06
            next_ovf = s_ovf;
         end
         hmac_pkg::HMAC_MODE_USAT: begin
            next_result = u_ovf ? usat_res : wrap_res; // RULE_07
            next_ovf = u_ovf;
         end
         hmac_pkg::HMAC_MODE_WRAP: begin
            next_result = wrap_res;
            next_ovf = s1_signed ? s_ovf : u_ovf;
         end
      endcase
   end

   // summary flag seen by the condition field and the flag update
   wire logic next_so = summary_flag_in | (s1_oe & next_ovf); // RULE_09 RULE_12
   wire logic res_neg = next_result[31];
   wire logic res_zero = next_result == hmac_pkg::WORD_RST;
   logic [3:0] next_cf;
   always_comb begin
      next_cf = hmac_pkg::CF_RST;
      next_cf[hmac_pkg::CF_LT] = res_neg; // RULE_12
      next_cf[hmac_pkg::CF_GT] = ~res_neg & ~res_zero; // RULE_12
      next_cf[hmac_pkg::CF_EQ] = res_zero; // RULE_12
      next_cf[hmac_pkg::CF_SO] = next_so; // RULE_12
   end

   ////////////////////////////////////////////////////////////////
   // result and status registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         result_valid <= 1'b0;
         illegal_op <= 1'b0;
         result <= hmac_pkg::WORD_RST;
         dest_index <= hmac_pkg::REG_RST;
         record_condition_bit <= 1'b0;
         overflow_update <= 1'b0;
      end else begin
         result_valid <= s1_valid;
         illegal_op <= s1_bad;
         // hold last value between operations
         if (s1_valid) begin
            result <= next_result;
            dest_index <= s1_rt;
         end
         record_condition_bit <= s1_valid & s1_rc; // RULE_08
         overflow_update <= s1_valid & s1_oe; // RULE_09
      end
   end

   // condition field changes only on a recording operation
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         condition_field_zero <= hmac_pkg::CF_RST;
      end else if (s1_valid && s1_rc) begin
         condition_field_zero <= next_cf; // RULE_08
      end
   end

   // exception flags change only with overflow enable set
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         result_too_wide_flag <= 1'b0;
         summary_overflow_flag <= 1'b0;
      end else if (s1_valid && s1_oe) begin
         result_too_wide_flag <= next_ovf; // RULE_09
         summary_overflow_flag <= next_so; // RULE_09
      end
   end
endmodule

// *** hmac_datapath_props.sv ***
`timescale 1ns/1ps
// port-level checks of the mac datapath
module hmac_datapath_props (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire logic [31:0] insn,
   input wire logic [31:0] first_source_reg,
   input wire logic [31:0] second_source_reg,
   input wire logic [31:0] accumulator_dest_reg,
   input wire logic summary_flag_in,
   input wire logic result_valid,
   input wire logic [31:0] result,
   input wire logic [4:0] dest_index,
   input wire logic illegal_op,
   input wire logic record_condition_bit,
   input wire logic [3:0] condition_field_zero,
   input wire logic overflow_update,
   input wire logic result_too_wide_flag,
   input wire logic summary_overflow_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   property p_lat; result_valid |-> $past(issue_valid, 2); endproperty
   a_lat: assert property (p_lat) else $error("result without issue");
   property p_prim; issue_valid && insn[31:26] != 6'h04 |-> ##2 illegal_op; endproperty
   a_prim: assert property (p_prim) else $error("bad primary accepted");
   property p_go; issue_valid && insn[31:26] == 6'h04 && insn[9:1] == 9'h18C |-> ##2 result_valid;
   endproperty
   a_go: assert property (p_go) else $error("low unsigned op lost");
   property p_rc; record_condition_bit |-> result_valid && $past(insn[0], 2); endproperty
   a_rc: assert property (p_rc) else $error("record pulse wrong");
   property p_cfh; !record_condition_bit |-> $stable(condition_field_zero); endproperty
   a_cfh: assert property (p_cfh) else $error("condition changed");
   property p_oe; overflow_update |-> result_valid && $past(insn[10], 2); endproperty
   a_oe: assert property (p_oe) else $error("overflow pulse wrong");
   property p_ovh; !overflow_update |-> $stable({result_too_wide_flag, summary_overflow_flag});
   endproperty
   a_ovh: assert property (p_ovh) else $error("flags changed");
   property p_cf; record_condition_bit |-> condition_field_zero[1] == (result == 32'h0)
      && condition_field_zero[3] == result[31]; endproperty
   a_cf: assert property (p_cf) else $error("condition value wrong");
   property p_sum; overflow_update |->
      summary_overflow_flag == ($past(summary_flag_in, 1) | result_too_wide_flag); endproperty
   a_sum: assert property (p_sum) else $error("summary wrong");
endmodule
bind hmac_datapath hmac_datapath_props chk (.mclk(mclk), .rst_n(rst_n),
   .issue_valid(issue_valid), .insn(insn), .first_source_reg(first_source_reg),
   .second_source_reg(second_source_reg), .accumulator_dest_reg(accumulator_dest_reg),
   .summary_flag_in(summary_flag_in), .result_valid(result_valid), .result(result),
   .dest_index(dest_index), .illegal_op(illegal_op), .record_condition_bit(record_condition_bit),
   .condition_field_zero(condition_field_zero), .overflow_update(overflow_update),
   .result_too_wide_flag(result_too_wide_flag), .summary_overflow_flag(summary_overflow_flag));

// *** hmac_pipe_model.sv ***
`timescale 1ns/1ps
// pipeline side: holds the sticky summary bit of the exception register
module hmac_pipe_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic overflow_update,
   input wire logic summary_overflow_flag,
   output logic summary_flag_in
);
   // sticky bit, written back only by overflow-enabled ops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         summary_flag_in <= 1'h0;
      end else if (overflow_update) begin
         summary_flag_in <= summary_overflow_flag;
      end
   end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [8:0] x; logic [31:0] a, b, t, r; logic v;} hmac_row_s;
   localparam logic [31:0] A0 = 32'hFFFE0003; // hi -2, lo 3
   localparam logic [31:0] B0 = 32'h0004FFFF; // hi 4, lo -1
   localparam logic [31:0] T0 = 32'h00000010;
   localparam logic [31:0] HM = 32'hFFFF0000;
   localparam logic [31:0] Z = 32'h00000000;
   hmac_row_s rows [17] = '{'{hmac_pkg::XO_HHW_S, A0, B0, T0, 32'h00000008, 1'h0},
      '{hmac_pkg::XO_HHW_SS, A0, B0, T0, 32'h00000008, 1'h0},
      '{hmac_pkg::XO_HHW_SU, A0, B0, T0, 32'h00040008, 1'h0},
      '{hmac_pkg::XO_HHW_U, A0, B0, T0, 32'h00040008, 1'h0},
      '{hmac_pkg::XO_LHW_S, A0, B0, T0, 32'h0000000D, 1'h0},
      '{hmac_pkg::XO_LHW_SS, A0, B0, T0, 32'h0000000D, 1'h0},
      '{hmac_pkg::XO_LHW_SU, A0, B0, T0, 32'h0003000D, 1'h0},
      '{hmac_pkg::XO_LHW_U, A0, B0, T0, 32'h0003000D, 1'h0},
      '{hmac_pkg::XO_CHW_U, A0, B0, T0, 32'h0000001C, 1'h0},
      '{hmac_pkg::XO_CHW_S, A0, B0, T0, 32'h0000001C, 1'h0},
      '{hmac_pkg::XO_CHW_SS, A0, B0, T0, 32'h0000001C, 1'h0},
      '{hmac_pkg::XO_CHW_SU, A0, B0, T0, 32'h0000001C, 1'h0},
      '{hmac_pkg::XO_HHW_SS, 32'h7FFF0000, 32'h7FFF0000, 32'h7FFFFFFF, 32'h7FFFFFFF, 1'h1},
      '{hmac_pkg::XO_LHW_SS, 32'h00008000, 32'h00007FFF, 32'h80000000, 32'h80000000, 1'h1},
      '{hmac_pkg::XO_HHW_SU, HM, HM, 32'h00020000, 32'hFFFFFFFF, 1'h1},
      '{hmac_pkg::XO_HHW_U, HM, HM, 32'h00020000, 32'h00000001, 1'h1},
      '{hmac_pkg::XO_LHW_U, Z, Z, Z, Z, 1'h0}};
   logic mclk = 1'h0, rst_n = 1'h0, iv = 1'h0, so_exp = 1'h0;
   logic [31:0] insn = Z, sa = Z, sb = Z, acc = Z, res;
   logic rv, ill, rcb, ovu, ov, so, sfi;
   logic [4:0] di;
   logic [3:0] cf, cf_exp;
   int mismatches = 0, tests_run = 0;
   hmac_datapath dut (.mclk(mclk), .rst_n(rst_n), .issue_valid(iv), .insn(insn),
      .first_source_reg(sa), .second_source_reg(sb), .accumulator_dest_reg(acc),
      .summary_flag_in(sfi), .result_valid(rv), .result(res), .dest_index(di),
      .illegal_op(ill), .record_condition_bit(rcb), .condition_field_zero(cf),
      .overflow_update(ovu), .result_too_wide_flag(ov), .summary_overflow_flag(so));
   hmac_pipe_model pipe (.mclk(mclk), .rst_n(rst_n), .overflow_update(ovu),
      .summary_overflow_flag(so), .summary_flag_in(sfi));
   initial forever #2.5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////
   // compare and count
   task chk(input string n, input logic [63:0] s, input logic [63:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   // verdict and end of run
   task conclude;
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // present one op at the falling edge, target register 7
   task drive(input logic [5:0] p, input logic [8:0] x, input logic oe, input logic rc,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] t);
      @(negedge mclk);
      iv = 1'h1;
      insn = {p, 5'h07, 5'h01, 5'h02, oe, x, rc};
      sa = a;
      sb = b;
      acc = t;
   endtask
   // single op; returns while its two-cycle answer stands
   task issue(input logic [5:0] p, input logic [8:0] x, input logic oe, input logic rc,
      input logic [31:0] a, input logic [31:0] b, input logic [31:0] t);
      drive(p, x, oe, rc, a, b, t);
      @(negedge mclk);
      iv = 1'h0;
      @(negedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge mclk);
      rst_n = 1'h1;
      chk("reset", {rv, ill, res, di, cf, ov, so}, Z);
      // every opcode with record and overflow enable
      foreach (rows[i]) begin
         issue(hmac_pkg::PRIMARY_OP, rows[i].x, 1'h1, 1'h1, rows[i].a, rows[i].b, rows[i].t);
         so_exp = so_exp | rows[i].v;
         cf_exp = {rows[i].r[31], !rows[i].r[31] && rows[i].r != Z, rows[i].r == Z, so_exp};
         chk("result", res, rows[i].r);
         chk("pulses", {rv, rcb, ovu, di}, 8'hE7);
         chk("flags", {ov, so}, {rows[i].v, so_exp});
         chk("cond", cf, cf_exp);
      end
      // wrong primary and unknown extended opcode refused
      issue(6'h05, hmac_pkg::XO_HHW_S, 1'h1, 1'h1, A0, B0, T0);
      chk("bad primary", {ill, rv, res}, {2'h2, Z});
      issue(hmac_pkg::PRIMARY_OP, 9'h000, 1'h1, 1'h1, A0, B0, T0);
      chk("bad opcode", {ill, rv, cf}, {2'h2, cf_exp});
      // overflowing wrap without record or enable
      issue(hmac_pkg::PRIMARY_OP, hmac_pkg::XO_HHW_S, 1'h0, 1'h0, 32'h7FFF0000, 32'h7FFF0000,
         32'h7FFFFFFF);
      chk("wrap", res, 32'hBFFF0000);
      chk("held", {rcb, ovu, cf, ov}, {2'h0, cf_exp, 1'h0});
      // back to back ops
      drive(hmac_pkg::PRIMARY_OP, hmac_pkg::XO_CHW_U, 1'h0, 1'h0, A0, B0, T0);
      drive(hmac_pkg::PRIMARY_OP, hmac_pkg::XO_LHW_S, 1'h0, 1'h0, A0, B0, T0);
      @(negedge mclk);
      iv = 1'h0;
      chk("first", {rv, res}, {1'h1, 32'h0000001C});
      @(negedge mclk);
      chk("second", {rv, res}, {1'h1, 32'h0000000D});
      // reset in mid-run clears everything
      rst_n = 1'h0;
      @(negedge mclk);
      chk("rereset", {rv, res, cf, ov, so}, Z);
      rst_n = 1'h1;
      // first op after release starts from clean flags
      issue(hmac_pkg::PRIMARY_OP, hmac_pkg::XO_LHW_U, 1'h1, 1'h1, A0, B0, T0);
      chk("after reset", {rv, res, cf, ov, so}, {1'h1, 32'h0003000D, 4'h4, 2'h0});
      conclude;
   end
endmodule
